// [rtl/arwd_pkg.sv]
// Package for the converter result post-processing and window detector.
// Assumes an 8-bit special-function-register port on the core clock.
package arwd_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_TRACK_TIME  = 8'hB9;
    localparam logic [7:0] ADDR_CTRL_ZERO   = 8'hC0;
    localparam logic [7:0] ADDR_CONFIG      = 8'hC1;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'hC2;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hC3;
    localparam logic [7:0] ADDR_UPPER_LOW   = 8'hC4;
    localparam logic [7:0] ADDR_UPPER_HIGH  = 8'hC5;
    localparam logic [7:0] ADDR_LOWER_LOW   = 8'hC6;
    localparam logic [7:0] ADDR_LOWER_HIGH  = 8'hC7;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_FLAG_BIT   = 3;
    localparam int CTRL_START_BIT  = 4;
    localparam int CFG_SHIFT_LSB   = 0;
    localparam int CFG_REPEAT_LSB  = 2;
    localparam int CFG_LEFT_BIT    = 4;
    localparam int CFG_EXTRA_BIT   = 5;
    localparam int TK_SAMPLE_BIT   = 7;
    localparam int LEFT_JUST_SHIFT = 6;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0]  TRACK_TIME_RESET = 8'h1E;
    localparam logic [7:0]  CONFIG_RESET     = 8'h00;
    localparam logic [15:0] UPPER_RESET      = 16'hFFFF;
    localparam logic [15:0] LOWER_RESET      = 16'h0000;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam logic [7:0] TRACK_BASE        = 8'h40;
    localparam int         SAR_CLK_DIV       = 4;
    localparam int         EXTRA_SAR_CLOCKS  = 4;
    localparam logic [7:0] EXTRA_TRACK_CYCLES = 8'(EXTRA_SAR_CLOCKS * SAR_CLK_DIV);
    localparam logic [2:0] SAMPLES_MULTI     = 3'h4;
    localparam logic [2:0] SAMPLES_SINGLE    = 3'h1;
    // ----------------------------------------
    // Burst sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ARWD_IDLE = 3'b001,
        ARWD_CONV = 3'b010,
        ARWD_GAP  = 3'b100
    } arwd_state_t;
endpackage

// [rtl/arwd_core.sv]
// Result accumulator, right shifter, window detector and burst timing.
// Assumes conv_valid is a one-cycle pulse per finished conversion and that
// the converter clock is ref_clk divided by SAR_CLK_DIV.
// Functional notes
// RULE1 - Keep a 16-bit sum of results, presented shifted right zero to three places.
// RULE2 - Repeat counts 4, 16, 64 with shifts 1, 2, 3 give 11-13 bit results.
// RULE3 - Every new result is compared with both limits without software action.
// RULE4 - A met window condition sets a flag in control register zero.
// RULE5 - Upper limit below lower limit flags results strictly between them.
// RULE6 - Otherwise flag results strictly below the lower or above the upper limit.
// RULE7 - Single-ended results are 10-bit unsigned, zero to full scale times 1023/1024.
// RULE8 - Left and right justified results use the same limit contents.
// RULE9 - Track-time register at 0xB9: sample select, reserved, tracking count, all RW.
// RULE10 - Gap of 64 minus count cycles, plus four converter clocks; none before first.
// RULE11 - Sample select 0 samples four times per conversion, 1 samples once.
// RULE12 - Each high and low byte pair compares as one 16-bit unsigned value.
`timescale 1ns/1ps
module arwd_core (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        conv_valid,
    input  wire logic [9:0]  conv_data,
    output logic             conv_start,
    output logic [2:0]       samples_per_conv,
    output logic             window_flag,
    output logic             result_valid
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    arwd_pkg::arwd_state_t state_reg, state_next;
    logic [7:0]  track_reg, track_next;
    logic [7:0]  cfg_reg, cfg_next;
    logic [15:0] upper_reg, upper_next;
    logic [15:0] lower_reg, lower_next;
    logic [15:0] acc_reg, acc_next;
    logic [15:0] result_reg, result_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic [7:0]  gap_reg, gap_next;
    logic        flag_reg, flag_next;
    logic        start_reg, start_next;
    logic        rvalid_reg, rvalid_next;
    logic [2:0]  spc_reg, spc_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic [15:0] sum;
    logic [15:0] word;
    logic [5:0]  rep_last;
    logic [7:0]  gap_len;
    logic        last_conv;
    logic        win_hit;
    logic        wr_ctrl;
    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        case (cfg_reg[arwd_pkg::CFG_REPEAT_LSB +: 2])
            2'h1:    rep_last = 6'h03;
            2'h2:    rep_last = 6'h0F;
            2'h3:    rep_last = 6'h3F;
            default: rep_last = 6'h00;
        endcase
        // Sum of 64 ten-bit results fits 16 bits, so no overflow check
        sum = acc_reg + {6'h00, conv_data}; // [RULE1] [RULE7]
        last_conv = conv_valid && (cnt_reg == rep_last); // [RULE2]
        word = sum >> cfg_reg[arwd_pkg::CFG_SHIFT_LSB +: 2]; // [RULE1] [RULE2]
        if (cfg_reg[arwd_pkg::CFG_LEFT_BIT])
        begin
            word = word << arwd_pkg::LEFT_JUST_SHIFT;
        end
        // Same limits whatever the justification; software scales them [RULE8]
        if (upper_reg < lower_reg)
        begin
            win_hit = (word > upper_reg) && (word < lower_reg); // [RULE5] [RULE12]
        end
        else
        begin
            win_hit = (word < lower_reg) || (word > upper_reg); // [RULE6] [RULE12]
        end
        win_hit = win_hit && last_conv; // [RULE3]
        gap_len = (arwd_pkg::TRACK_BASE - {2'h0, track_reg[5:0]})
                + (cfg_reg[arwd_pkg::CFG_EXTRA_BIT] ? arwd_pkg::EXTRA_TRACK_CYCLES : 8'h00);
        wr_ctrl = sfr_wr && (sfr_addr == arwd_pkg::ADDR_CTRL_ZERO);
        track_next = track_reg;
        cfg_next = cfg_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        if (sfr_wr)
        begin
            if (sfr_addr == arwd_pkg::ADDR_TRACK_TIME)
                track_next = sfr_wdata; // [RULE9]
            else if (sfr_addr == arwd_pkg::ADDR_CONFIG)
                cfg_next = sfr_wdata;
            else if (sfr_addr == arwd_pkg::ADDR_UPPER_LOW)
                upper_next[7:0] = sfr_wdata;
            else if (sfr_addr == arwd_pkg::ADDR_UPPER_HIGH)
                upper_next[15:8] = sfr_wdata;
            else if (sfr_addr == arwd_pkg::ADDR_LOWER_LOW)
                lower_next[7:0] = sfr_wdata;
            else if (sfr_addr == arwd_pkg::ADDR_LOWER_HIGH)
                lower_next[15:8] = sfr_wdata;
        end
        // Hardware set wins over a software clear in the same cycle
        flag_next = flag_reg;
        if (wr_ctrl)
            flag_next = sfr_wdata[arwd_pkg::CTRL_FLAG_BIT];
        if (win_hit)
            flag_next = 1'b1; // [RULE4]
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        rvalid_next = 1'b0;
        if (last_conv)
        begin
            acc_next = 16'h0000;
            cnt_next = 6'h00;
            result_next = word;
            rvalid_next = 1'b1;
        end
        else if (conv_valid)
        begin
            acc_next = sum;
            cnt_next = cnt_reg + 6'h01;
        end
        state_next = state_reg;
        gap_next = gap_reg;
        start_next = 1'b0;
        case (state_reg)
            arwd_pkg::ARWD_IDLE:
            begin
                if (wr_ctrl && sfr_wdata[arwd_pkg::CTRL_START_BIT])
                begin
                    start_next = 1'b1; // [RULE10]
                    state_next = arwd_pkg::ARWD_CONV;
                end
            end
            arwd_pkg::ARWD_CONV:
            begin
                if (last_conv)
                    state_next = arwd_pkg::ARWD_IDLE;
                else if (conv_valid)
                begin
                    gap_next = gap_len; // [RULE10]
                    state_next = arwd_pkg::ARWD_GAP;
                end
            end
            arwd_pkg::ARWD_GAP:
            begin
                if (gap_reg <= 8'h01)
                begin
                    start_next = 1'b1;
                    state_next = arwd_pkg::ARWD_CONV;
                end
                gap_next = gap_reg - 8'h01;
            end
            default: state_next = arwd_pkg::ARWD_IDLE;
        endcase
        spc_next = track_reg[arwd_pkg::TK_SAMPLE_BIT] ? arwd_pkg::SAMPLES_SINGLE
                                                      : arwd_pkg::SAMPLES_MULTI; // [RULE11]
        // Unmapped addresses read zero
        if (sfr_addr == arwd_pkg::ADDR_TRACK_TIME)
            rdata_next = track_reg;
        else if (sfr_addr == arwd_pkg::ADDR_CTRL_ZERO)
            rdata_next = {3'h0, state_reg != arwd_pkg::ARWD_IDLE, flag_reg, 3'h0};
        else if (sfr_addr == arwd_pkg::ADDR_CONFIG)
            rdata_next = cfg_reg;
        else if (sfr_addr == arwd_pkg::ADDR_RESULT_LOW)
            rdata_next = result_reg[7:0];
        else if (sfr_addr == arwd_pkg::ADDR_RESULT_HIGH)
            rdata_next = result_reg[15:8];
        else if (sfr_addr == arwd_pkg::ADDR_UPPER_LOW)
            rdata_next = upper_reg[7:0];
        else if (sfr_addr == arwd_pkg::ADDR_UPPER_HIGH)
            rdata_next = upper_reg[15:8];
        else if (sfr_addr == arwd_pkg::ADDR_LOWER_LOW)
            rdata_next = lower_reg[7:0];
        else if (sfr_addr == arwd_pkg::ADDR_LOWER_HIGH)
            rdata_next = lower_reg[15:8];
        else
            rdata_next = 8'h00;
    end
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg  <= arwd_pkg::ARWD_IDLE;
            track_reg  <= arwd_pkg::TRACK_TIME_RESET;
            cfg_reg    <= arwd_pkg::CONFIG_RESET;
            upper_reg  <= arwd_pkg::UPPER_RESET;
            lower_reg  <= arwd_pkg::LOWER_RESET;
            acc_reg    <= 16'h0000;
            result_reg <= 16'h0000;
            cnt_reg    <= 6'h00;
            gap_reg    <= 8'h00;
            flag_reg   <= 1'b0;
            start_reg  <= 1'b0;
            rvalid_reg <= 1'b0;
            spc_reg    <= arwd_pkg::SAMPLES_MULTI;
            rdata_reg  <= 8'h00;
        end
        else
        begin
            state_reg  <= state_next;
            track_reg  <= track_next;
            cfg_reg    <= cfg_next;
            upper_reg  <= upper_next;
            lower_reg  <= lower_next;
            acc_reg    <= acc_next;
            result_reg <= result_next;
            cnt_reg    <= cnt_next;
            gap_reg    <= gap_next;
            flag_reg   <= flag_next;
            start_reg  <= start_next;
            rvalid_reg <= rvalid_next;
            spc_reg    <= spc_next;
            rdata_reg  <= rdata_next;
        end
    end
    assign sfr_rdata        = rdata_reg;
    assign conv_start       = start_reg;
    assign samples_per_conv = spc_reg;
    assign window_flag      = flag_reg;
    assign result_valid     = rvalid_reg;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_shift_three;
        @(posedge ref_clk) disable iff (rst)
        (last_conv && cfg_reg[1:0] == 2'h3 && !cfg_reg[arwd_pkg::CFG_LEFT_BIT])
        |=> rvalid_reg && result_reg == ($past(sum) >> 3);
    endproperty
    a_shift_three: assert property (p_shift_three) else $error("shift wrong"); // [RULE1]
    property p_repeat;
        @(posedge ref_clk) disable iff (rst)
        (conv_valid && cnt_reg != rep_last) |=> !rvalid_reg;
    endproperty
    a_repeat: assert property (p_repeat) else $error("early result"); // [RULE2]
    property p_flag_set;
        @(posedge ref_clk) disable iff (rst)
        win_hit |=> flag_reg && rvalid_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // [RULE4]
    property p_inside;
        @(posedge ref_clk) disable iff (rst)
        (last_conv && upper_reg < lower_reg && word > upper_reg && word < lower_reg)
        |=> flag_reg;
    endproperty
    a_inside: assert property (p_inside) else $error("inside miss"); // [RULE5]
    property p_outside;
        @(posedge ref_clk) disable iff (rst)
        (last_conv && upper_reg >= lower_reg && !(word > upper_reg) && !(word < lower_reg)
         && !flag_reg && !wr_ctrl) |=> !flag_reg;
    endproperty
    a_outside: assert property (p_outside) else $error("false outside"); // [RULE6]
    property p_track_wr;
        @(posedge ref_clk) disable iff (rst)
        (sfr_wr && sfr_addr == arwd_pkg::ADDR_TRACK_TIME)
        ##1 (sfr_addr == arwd_pkg::ADDR_TRACK_TIME) |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_track_wr: assert property (p_track_wr) else $error("track readback"); // [RULE9]
    property p_first_start;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == arwd_pkg::ARWD_IDLE && wr_ctrl && sfr_wdata[arwd_pkg::CTRL_START_BIT])
        |=> conv_start;
    endproperty
    a_first_start: assert property (p_first_start) else $error("first delayed"); // [RULE10]
    property p_gap;
        @(posedge ref_clk) disable iff (rst)
        (state_reg == arwd_pkg::ARWD_CONV && conv_valid && !last_conv)
        |=> gap_reg == $past(gap_len) && !conv_start;
    endproperty
    a_gap: assert property (p_gap) else $error("gap length"); // [RULE10]
    property p_samples;
        @(posedge ref_clk) disable iff (rst)
        track_reg[arwd_pkg::TK_SAMPLE_BIT] ##1 track_reg[arwd_pkg::TK_SAMPLE_BIT]
        |-> samples_per_conv == arwd_pkg::SAMPLES_SINGLE;
    endproperty
    a_samples: assert property (p_samples) else $error("sample count"); // [RULE11]
endmodule // arwd_core

// [dv/arwd_core_test.sv]
// Self-checking bench for the result accumulator, shifter and window detector.
// Assumes the core alone: the bench plays both the converter and the register master.
`timescale 1ns/1ps
module arwd_core_test;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    localparam int CYCLE_LIMIT = 5000;
    logic       ref_clk, rst, sfr_wr, conv_valid;
    logic       conv_start, window_flag, result_valid;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [9:0] conv_data;
    logic [2:0] samples_per_conv;
    int         n_errors, tests_run, cyc;

    arwd_core dut (
        .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_valid(conv_valid),
        .conv_data(conv_data), .conv_start(conv_start),
        .samples_per_conv(samples_per_conv), .window_flag(window_flag),
        .result_valid(result_valid)
    );

    always #2 ref_clk = ~ref_clk;

    // Hang guard: the full sequence needs roughly nine hundred cycles
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == CYCLE_LIMIT)
        begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_val({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wr    <= 1'b1;
        sfr_wdata <= d;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask

    // Read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = sfr_rdata;
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a + 8'h01, v[15:8]);
        rd(a, v[7:0]);
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask

    task automatic conv(input logic [9:0] d);
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_data  <= d;
        @(posedge ref_clk);
        conv_valid <= 1'b0;
    endtask

    task automatic wait_rv();
        int k;
        k = 0;
        @(negedge ref_clk);
        while (result_valid !== 1'b1 && k < 4)
        begin
            @(negedge ref_clk);
            k++;
        end
        cmp_bit(result_valid, 1'b1, "result_valid");
    endtask

    task automatic shot(input logic [9:0] d, input logic ex);
        logic [7:0] c;
        conv(d);
        wait_rv();
        repeat (2) @(negedge ref_clk);
        cmp_bit(window_flag, ex, "window_flag");
        rd(arwd_pkg::ADDR_CTRL_ZERO, c);
        cmp_bit(c[3], ex, "control flag bit");
        wr(arwd_pkg::ADDR_CTRL_ZERO, 8'h00);
        repeat (2) @(negedge ref_clk);
        cmp_bit(window_flag, 1'b0, "flag cleared");
    endtask

    task automatic wait_start(output int at);
        int k;
        k = 0;
        while (conv_start !== 1'b1 && k < 200)
        begin
            @(negedge ref_clk);
            k++;
        end
        cmp_bit(conv_start, 1'b1, "conv_start");
        at = cyc;
    endtask

    // Burst of four; the converter answers late on the first start on purpose
    task automatic burst(input logic [7:0] cfg, input logic [7:0] tk, output int gap);
        logic [7:0] c;
        int at, cv, g1, n;
        wr(arwd_pkg::ADDR_CONFIG, cfg);
        wr(arwd_pkg::ADDR_TRACK_TIME, tk);
        wr(arwd_pkg::ADDR_CTRL_ZERO, 8'h10);
        @(negedge ref_clk);
        cmp_bit(conv_start, 1'b1, "first start without gap");
        rd(arwd_pkg::ADDR_CTRL_ZERO, c);
        cmp_bit(c[4], 1'b1, "busy during burst");
        for (int i = 0; i < 4; i++)
        begin
            if (i > 0)
            begin
                wait_start(at);
                gap = at - cv;
                if (i == 1)
                    g1 = gap;
                cmp_val(16'(gap), 16'(g1), "equal gaps");
            end
            conv(10'(i));
            @(negedge ref_clk);
            cv = cyc;
        end
        n = 0;
        repeat (100)
        begin
            @(negedge ref_clk);
            if (conv_start === 1'b1)
                n++;
        end
        cmp_val(16'(n), 16'h0000, "start after last conversion");
        rd(arwd_pkg::ADDR_CTRL_ZERO, c);
        cmp_bit(c[4], 1'b0, "idle after burst");
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0]  b;
        logic [15:0] v;
        int          d0, d1, d2;
        ref_clk = 1'b0;
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        conv_valid = 1'b0;
        conv_data = 10'h000;
        n_errors = 0;
        tests_run = 0;
        cyc = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd(arwd_pkg::ADDR_TRACK_TIME, b);
        cmp_val(16'(b), 16'h001E, "track time reset");
        rd16(arwd_pkg::ADDR_UPPER_LOW, v);
        cmp_val(v, 16'hFFFF, "upper reset");
        rd16(arwd_pkg::ADDR_LOWER_LOW, v);
        cmp_val(v, 16'h0000, "lower reset");
        rd(8'hA0, b);
        cmp_val(16'(b), 16'h0000, "unmapped read");
        cmp_val(16'(samples_per_conv), 16'h0004, "four samples");
        wr(arwd_pkg::ADDR_TRACK_TIME, 8'hC5);
        rd(arwd_pkg::ADDR_TRACK_TIME, b);
        cmp_val(16'(b), 16'h00C5, "track time rw");
        cmp_val(16'(samples_per_conv), 16'h0001, "single sample");
        // Repeat 1/4/16/64 with shift 0..3, full-scale-ish data
        for (int m = 0; m < 4; m++)
        begin
            wr(arwd_pkg::ADDR_CONFIG, 8'(m * 5));
            repeat (1 << (2 * m)) conv(10'h3FF - 10'(m));
            wait_rv();
            rd16(arwd_pkg::ADDR_RESULT_LOW, v);
            cmp_val(v, 16'(((1 << (2 * m)) * (1023 - m)) >> m), "sum");
        end
        wr(arwd_pkg::ADDR_RESULT_LOW, 8'h00);
        rd16(arwd_pkg::ADDR_RESULT_LOW, v);
        cmp_val(v, 16'h1FE0, "result read only");
        wr(arwd_pkg::ADDR_CONFIG, 8'h00);
        wr16(arwd_pkg::ADDR_UPPER_LOW, 16'h0040);
        wr16(arwd_pkg::ADDR_LOWER_LOW, 16'h0080);
        shot(10'h040, 1'b0);
        shot(10'h041, 1'b1);
        shot(10'h07F, 1'b1);
        shot(10'h080, 1'b0);
        wr16(arwd_pkg::ADDR_UPPER_LOW, 16'h0080);
        wr16(arwd_pkg::ADDR_LOWER_LOW, 16'h0040);
        shot(10'h03F, 1'b1);
        shot(10'h040, 1'b0);
        shot(10'h080, 1'b0);
        shot(10'h081, 1'b1);
        // Left-justified: result is the sample moved up six places
        wr(arwd_pkg::ADDR_CONFIG, 8'h10);
        wr16(arwd_pkg::ADDR_UPPER_LOW, 16'h0040);
        wr16(arwd_pkg::ADDR_LOWER_LOW, 16'h1000);
        shot(10'h001, 1'b0);
        shot(10'h002, 1'b1);
        shot(10'h040, 1'b0);
        // Limits straddle a byte boundary, so a low-byte-only compare fails
        wr(arwd_pkg::ADDR_CONFIG, 8'h00);
        wr16(arwd_pkg::ADDR_UPPER_LOW, 16'h00FF);
        wr16(arwd_pkg::ADDR_LOWER_LOW, 16'h0101);
        shot(10'h100, 1'b1);
        shot(10'h0FF, 1'b0);
        shot(10'h101, 1'b0);
        burst(8'h04, 8'h3C, d0);
        burst(8'h24, 8'h3C, d1);
        burst(8'h04, 8'h38, d2);
        cmp_val(16'(d0), 16'h0004, "base gap");
        cmp_val(16'(d1 - d0), 16'h0010, "extra track gap");
        cmp_val(16'(d2 - d0), 16'h0004, "count gap");
        cmp_val(16'(samples_per_conv), 16'h0004, "four samples");
        report_and_stop();
    end
endmodule // arwd_core_test
